// [src/hup_pkg.sv]
/*
 * Shared constants and types of the host serial packet port: register map, field positions,
 * reset values, oversampling and parity codes, packet type codes and event bit positions.
 * Assumes an APB slave with a 12-bit byte address and one register per aligned 32-bit word.
 */
package hup_pkg;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_DIV = 12'h004;
    localparam logic [11:0] OFS_DATA = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [11:0] OFS_CLEAR = 12'h010;
    localparam logic [11:0] OFS_ENABLE = 12'h014;
    localparam logic [11:0] OFS_PKTSTAT = 12'h018;
    localparam logic [11:0] OFS_PKTCTRL = 12'h01c;
    localparam logic [3:0] WIN_RXBUF = 4'h1;
    localparam logic [3:0] WIN_TXBUF = 4'h2;

    localparam int BUF_DEPTH = 64;
    localparam logic [6:0] BUF_DEPTH_L = 7'h40;

    localparam logic [1:0] OSR_X16 = 2'h0;
    localparam logic [1:0] OSR_X24 = 2'h1;
    localparam logic [1:0] OSR_X13 = 2'h2;
    localparam logic [4:0] TICKS_X16 = 5'h10;
    localparam logic [4:0] TICKS_X24 = 5'h18;
    localparam logic [4:0] TICKS_X13 = 5'h0d;

    localparam logic [2:0] PAR_NONE = 3'h0;
    localparam logic [2:0] PAR_EVEN = 3'h1;
    localparam logic [2:0] PAR_ODD = 3'h2;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [2:0] PAR_SPACE = 3'h4;

    localparam logic [7:0] TYPE_CMD = 8'h01;
    localparam logic [7:0] TYPE_ACL = 8'h02;
    localparam logic [7:0] TYPE_SCO = 8'h03;
    localparam logic [7:0] TYPE_EVT = 8'h04;
    localparam logic [6:0] HDR_CMD = 7'h03;
    localparam logic [6:0] HDR_ACL = 7'h04;
    localparam logic [6:0] HDR_SCO = 7'h03;
    localparam logic [6:0] HDR_EVT = 7'h02;

    localparam int EV_RX_RDY = 0;
    localparam int EV_TX_EMPTY = 1;
    localparam int EV_PERR = 2;
    localparam int EV_FERR = 3;
    localparam int EV_OVR = 4;
    localparam int EV_BRK = 5;
    localparam int EV_PKT_RX = 6;
    localparam int EV_PKT_TX = 7;
    localparam int EV_PKT_BAD = 8;
    localparam int EV_W = 9;
    localparam logic [8:0] ERR_MASK = 9'h03c;

    localparam int PC_START = 0;
    localparam int PC_RELEASE = 1;
    localparam int PC_CONT = 2;
    localparam int PC_LEN_LSB = 8;
    localparam int PC_TYPE_LSB = 16;
    localparam int PS_LEN_LSB = 8;
    localparam int PS_AVAIL = 16;
    localparam int PS_TXBUSY = 17;
    localparam int PS_RXBUSY = 18;

    typedef struct packed {
        logic [2:0] parity;
        logic stop2;
        logic data8;
        logic [1:0] osr;
        logic brk;
        logic hci;
    } hup_cfg_t;

    localparam logic [8:0] CTRL_RST = 9'h010;
    localparam logic [15:0] DIV_RST = 16'h0000;
endpackage

// [src/hup_top.sv]
/*
 * Host serial packet port: full-duplex UART with divider and selectable oversampling,
 * character format, break send and detect, sticky interrupts, and a packet engine that
 * parses, frames and buffers host packets in a local packet memory.
 * Assumes APB from the embedded processor and a serial line synchronous to clk.
 */
`timescale 1ns/1ps
module hup_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic uart_rxd,
    output logic uart_txd,
    output logic irq,
    output logic err_irq
);
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} hup_rx_t;
    typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} hup_tx_t;
    typedef enum logic [1:0] {P_IDLE, P_HDR, P_PAY, P_HOLD} hup_pk_t;

    function automatic logic [4:0] osr_ticks(input logic [1:0] sel);
        osr_ticks = (sel == hup_pkg::OSR_X24) ? hup_pkg::TICKS_X24 :
                    (sel == hup_pkg::OSR_X13) ? hup_pkg::TICKS_X13 : hup_pkg::TICKS_X16;
    endfunction

    function automatic logic par_bit(input logic [2:0] mode, input logic [7:0] d);
        par_bit = (mode == hup_pkg::PAR_EVEN) ? ^d :
                  (mode == hup_pkg::PAR_ODD) ? ~^d :
                  (mode == hup_pkg::PAR_MARK);
    endfunction

    // Header bytes after the type byte; zero marks an unknown type
    function automatic logic [6:0] hdr_len(input logic [7:0] t);
        hdr_len = (t == hup_pkg::TYPE_CMD) ? hup_pkg::HDR_CMD :
                  (t == hup_pkg::TYPE_ACL) ? hup_pkg::HDR_ACL :
                  (t == hup_pkg::TYPE_SCO) ? hup_pkg::HDR_SCO :
                  (t == hup_pkg::TYPE_EVT) ? hup_pkg::HDR_EVT : 7'h00;
    endfunction

    hup_pkg::hup_cfg_t cfg_r;
    logic [15:0] div_r;
    logic [8:0] st_r;
    logic [8:0] en_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [7:0] rx_buf [hup_pkg::BUF_DEPTH];
    logic [7:0] tx_buf [hup_pkg::BUF_DEPTH];

    // APB decode; every access completes with no wait state
    wire acc = psel & penable;
    wire setup = psel & ~penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire hit_ctrl = paddr == hup_pkg::OFS_CTRL;
    wire hit_div = paddr == hup_pkg::OFS_DIV;
    wire hit_data = paddr == hup_pkg::OFS_DATA;
    wire hit_stat = paddr == hup_pkg::OFS_STATUS;
    wire hit_clr = paddr == hup_pkg::OFS_CLEAR;
    wire hit_en = paddr == hup_pkg::OFS_ENABLE;
    wire hit_pst = paddr == hup_pkg::OFS_PKTSTAT;
    wire hit_pct = paddr == hup_pkg::OFS_PKTCTRL;
    wire hit_rxb = (paddr[11:8] == hup_pkg::WIN_RXBUF) & (paddr[1:0] == 2'h0);
    wire hit_txb = (paddr[11:8] == hup_pkg::WIN_TXBUF) & (paddr[1:0] == 2'h0);
    wire [5:0] buf_idx = paddr[7:2];
    wire mapped = hit_ctrl | hit_div | hit_data | hit_stat | hit_clr | hit_en | hit_pst | hit_pct
                  | hit_rxb | hit_txb;
    wire pct_wr = wr & hit_pct;

    // Baud base tick, period div_r+1 clocks
    logic [15:0] bcnt_r;
    wire tick = bcnt_r >= div_r;
    wire [4:0] nbit = osr_ticks(cfg_r.osr);
    wire [4:0] half = {1'b0, nbit[4:1]};
    wire [2:0] last_bit = cfg_r.data8 ? 3'h7 : 3'h6;
    wire par_on = cfg_r.parity != hup_pkg::PAR_NONE;

    // Receiver
    hup_rx_t rx_st_r, rx_st_nxt;
    logic [4:0] rx_sc_r, rx_sc_nxt;
    logic [2:0] rx_bc_r, rx_bc_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic rx_pb_r, rx_pb_nxt;
    logic rxd_prev_r;
    logic rx_done, rx_perr, rx_ferr, rx_brk;
    wire [7:0] rx_data = cfg_r.data8 ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
    wire rx_ok = rx_done & ~rx_brk;

    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_sc_nxt = rx_sc_r;
        rx_bc_nxt = rx_bc_r;
        rx_sh_nxt = rx_sh_r;
        rx_pb_nxt = rx_pb_r;
        rx_done = 1'b0;
        rx_perr = 1'b0;
        rx_ferr = 1'b0;
        rx_brk = 1'b0;
        unique case (rx_st_r)
            R_IDLE: begin
                if (rxd_prev_r & ~uart_rxd) begin
                    rx_st_nxt = R_START;
                    rx_sc_nxt = 5'h00;
                end
            end
            R_START: begin
                if (tick) begin
                    if (rx_sc_r == half - 5'h01) begin
                        // A glitch that is high again at mid-bit is not a start
                        rx_st_nxt = uart_rxd ? R_IDLE : R_DATA;
                        rx_sc_nxt = 5'h00;
                        rx_bc_nxt = 3'h0;
                        rx_sh_nxt = 8'h00;
                    end else begin
                        rx_sc_nxt = rx_sc_r + 5'h01;
                    end
                end
            end
            R_DATA, R_PAR, R_STOP: begin
                if (tick) begin
                    rx_sc_nxt = rx_sc_r + 5'h01;
                    if (rx_sc_r == nbit - 5'h01) begin
                        rx_sc_nxt = 5'h00;
                        if (rx_st_r == R_DATA) begin
                            rx_sh_nxt = {uart_rxd, rx_sh_r[7:1]};
                            rx_bc_nxt = rx_bc_r + 3'h1;
                            if (rx_bc_r == last_bit) begin
                                rx_st_nxt = par_on ? R_PAR : R_STOP;
                            end
                        end else if (rx_st_r == R_PAR) begin
                            rx_pb_nxt = uart_rxd;
                            rx_st_nxt = R_STOP;
                        end else begin
                            // Only the first stop bit is checked so back-to-back frames stay aligned
                            rx_done = 1'b1;
                            rx_brk = ~uart_rxd & (rx_data == 8'h00) & (~par_on | ~rx_pb_r);
                            rx_ferr = ~uart_rxd & ~rx_brk;
                            rx_perr = par_on & (rx_pb_r != par_bit(cfg_r.parity, rx_data));
                            rx_st_nxt = R_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    // Direct path holding registers
    logic [7:0] rbr_r;
    logic rbr_full_r;
    logic [7:0] thr_r;
    logic thr_v_r;
    wire rx_direct = rx_ok & ~cfg_r.hci;
    wire rbr_rd = rd & hit_data;

    // Packet transmit engine
    logic ptx_busy_r;
    logic ptx_hdr_r;
    logic [7:0] ptx_type_r;
    logic [6:0] ptx_len_r;
    logic [6:0] ptx_ptr_r;
    wire ptx_start = pct_wr & pwdata[hup_pkg::PC_START] & cfg_r.hci & ~ptx_busy_r;
    wire [6:0] pct_len = pwdata[hup_pkg::PC_LEN_LSB +: 7];
    wire ptx_more = ptx_hdr_r | (ptx_ptr_r < ptx_len_r);
    wire [7:0] ptx_byte = ptx_hdr_r ? ptx_type_r : tx_buf[ptx_ptr_r[5:0]];
    wire src_v = cfg_r.hci ? (ptx_busy_r & ptx_more) : thr_v_r;
    wire [7:0] src_b = cfg_r.hci ? ptx_byte : thr_r;

    // Transmitter
    hup_tx_t tx_st_r, tx_st_nxt;
    logic [4:0] tx_sc_r, tx_sc_nxt;
    logic [2:0] tx_bc_r, tx_bc_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic tx_pb_r, tx_pb_nxt;
    logic tx_sb_r, tx_sb_nxt;
    logic txd_r;
    logic tx_fin;
    wire tx_take = (tx_st_r == T_IDLE) & src_v & ~cfg_r.brk;
    wire tx_bit_end = tick & (tx_sc_r == nbit - 5'h01);

    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_sc_nxt = tx_sc_r;
        tx_bc_nxt = tx_bc_r;
        tx_sh_nxt = tx_sh_r;
        tx_pb_nxt = tx_pb_r;
        tx_sb_nxt = tx_sb_r;
        tx_fin = 1'b0;
        if (tick) begin
            tx_sc_nxt = tx_sc_r + 5'h01;
        end
        if (tx_bit_end) begin
            tx_sc_nxt = 5'h00;
        end
        unique case (tx_st_r)
            T_IDLE: begin
                if (tx_take) begin
                    tx_st_nxt = T_START;
                    tx_sc_nxt = 5'h00;
                    tx_bc_nxt = 3'h0;
                    tx_sb_nxt = 1'b0;
                    tx_sh_nxt = cfg_r.data8 ? src_b : {1'b0, src_b[6:0]};
                    tx_pb_nxt = par_bit(cfg_r.parity, cfg_r.data8 ? src_b : {1'b0, src_b[6:0]});
                end
            end
            T_START: begin
                if (tx_bit_end) begin
                    tx_st_nxt = T_DATA;
                end
            end
            T_DATA: begin
                if (tx_bit_end) begin
                    tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                    tx_bc_nxt = tx_bc_r + 3'h1;
                    if (tx_bc_r == last_bit) begin
                        tx_st_nxt = par_on ? T_PAR : T_STOP;
                    end
                end
            end
            T_PAR: begin
                if (tx_bit_end) begin
                    tx_st_nxt = T_STOP;
                end
            end
            T_STOP: begin
                if (tx_bit_end) begin
                    if (cfg_r.stop2 & ~tx_sb_r) begin
                        tx_sb_nxt = 1'b1;
                    end else begin
                        tx_st_nxt = T_IDLE;
                        tx_fin = 1'b1;
                    end
                end
            end
        endcase
    end

    wire txd_line = (tx_st_r == T_START) ? 1'b0 :
                    (tx_st_r == T_DATA) ? tx_sh_r[0] :
                    (tx_st_r == T_PAR) ? tx_pb_r : 1'b1;

    // Packet receive engine
    hup_pk_t pk_st_r, pk_st_nxt;
    logic [6:0] pk_cnt_r, pk_cnt_nxt;
    logic [6:0] pk_tot_r, pk_tot_nxt;
    logic [7:0] pk_type_r, pk_type_nxt;
    logic pk_store, pk_done, pk_bad, pk_ovr;
    wire rx_hci = rx_ok & cfg_r.hci;
    wire hci_err = rx_perr | rx_ferr | rx_brk;
    wire pk_release = pct_wr & pwdata[hup_pkg::PC_RELEASE];
    wire [6:0] pk_hl = hdr_len(pk_type_r);
    wire [15:0] pk_plen = (pk_type_r == hup_pkg::TYPE_ACL) ? {rx_data, rx_buf[3]} : {8'h00, rx_data};
    wire [16:0] pk_tot_w = {10'h000, pk_hl} + 17'h0_0001 + {1'b0, pk_plen};

    always_comb begin
        pk_st_nxt = pk_st_r;
        pk_cnt_nxt = pk_cnt_r;
        pk_tot_nxt = pk_tot_r;
        pk_type_nxt = pk_type_r;
        pk_store = 1'b0;
        pk_done = 1'b0;
        pk_bad = 1'b0;
        pk_ovr = 1'b0;
        unique case (pk_st_r)
            P_IDLE: begin
                if (rx_hci) begin
                    if (hdr_len(rx_data) != 7'h00) begin
                        pk_store = 1'b1;
                        pk_type_nxt = rx_data;
                        pk_cnt_nxt = 7'h01;
                        pk_st_nxt = P_HDR;
                    end else begin
                        pk_bad = 1'b1;
                    end
                end
            end
            P_HDR, P_PAY: begin
                if (cfg_r.hci & hci_err) begin
                    // A line error leaves the frame boundary unknown, so the packet is dropped
                    pk_bad = 1'b1;
                    pk_st_nxt = P_IDLE;
                end else if (rx_hci) begin
                    pk_store = 1'b1;
                    pk_cnt_nxt = pk_cnt_r + 7'h01;
                    if (pk_st_r == P_HDR) begin
                        if (pk_cnt_r == pk_hl) begin
                            pk_tot_nxt = pk_tot_w[6:0];
                            if (pk_tot_w > {10'h000, hup_pkg::BUF_DEPTH_L}) begin
                                pk_bad = 1'b1;
                                pk_st_nxt = P_IDLE;
                            end else if (pk_plen == 16'h0000) begin
                                pk_done = 1'b1;
                                pk_st_nxt = P_HOLD;
                            end else begin
                                pk_st_nxt = P_PAY;
                            end
                        end
                    end else if (pk_cnt_r + 7'h01 == pk_tot_r) begin
                        pk_done = 1'b1;
                        pk_st_nxt = P_HOLD;
                    end
                end
            end
            P_HOLD: begin
                // Buffer is owned by software until released; new bytes are lost
                pk_ovr = rx_hci;
                if (pk_release) begin
                    pk_st_nxt = P_IDLE;
                end
            end
        endcase
    end

    // Interrupt status: set wins over a clear in the same cycle
    wire [8:0] ev = {pk_bad, ptx_busy_r & ~ptx_more & tx_fin, pk_done, rx_brk,
                     pk_ovr | (rx_direct & rbr_full_r), rx_ferr, rx_perr,
                     ~cfg_r.hci & tx_fin & ~thr_v_r, rx_direct};
    wire [8:0] clr = (wr & hit_clr) ? pwdata[8:0] : 9'h000;
    wire [8:0] st_nxt = (st_r & ~clr) | ev;

    wire [31:0] pktstat = {13'h0000, pk_st_r != P_IDLE && pk_st_r != P_HOLD, ptx_busy_r,
                           pk_st_r == P_HOLD, 1'b0, pk_cnt_r, pk_type_r};
    wire [31:0] rd_mux = hit_ctrl ? {23'h00_0000, cfg_r} :
                         hit_div ? {16'h0000, div_r} :
                         hit_data ? {24'h00_0000, rbr_r} :
                         hit_stat ? {23'h00_0000, st_r} :
                         hit_en ? {23'h00_0000, en_r} :
                         hit_pst ? pktstat :
                         hit_rxb ? {24'h00_0000, rx_buf[buf_idx]} : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r <= hup_pkg::CTRL_RST;
            div_r <= hup_pkg::DIV_RST;
            en_r <= 9'h000;
            st_r <= 9'h000;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            if (wr & hit_ctrl) begin
                cfg_r <= pwdata[8:0];
            end
            if (wr & hit_div) begin
                div_r <= pwdata[15:0];
            end
            if (wr & hit_en) begin
                en_r <= pwdata[8:0];
            end
            st_r <= st_nxt;
            if (setup) begin
                prdata_r <= rd_mux;
                pslverr_r <= ~mapped;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (wr & hit_txb) begin
            tx_buf[buf_idx] <= pwdata[7:0];
        end
        if (pk_store) begin
            rx_buf[pk_cnt_r[5:0]] <= rx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bcnt_r <= 16'h0000;
            rx_st_r <= R_IDLE;
            rx_sc_r <= 5'h00;
            rx_bc_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_pb_r <= 1'b0;
            rxd_prev_r <= 1'b1;
            tx_st_r <= T_IDLE;
            tx_sc_r <= 5'h00;
            tx_bc_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_pb_r <= 1'b0;
            tx_sb_r <= 1'b0;
            txd_r <= 1'b1;
        end else begin
            bcnt_r <= tick ? 16'h0000 : bcnt_r + 16'h0001;
            rx_st_r <= rx_st_nxt;
            rx_sc_r <= rx_sc_nxt;
            rx_bc_r <= rx_bc_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_pb_r <= rx_pb_nxt;
            rxd_prev_r <= uart_rxd;
            tx_st_r <= tx_st_nxt;
            tx_sc_r <= tx_sc_nxt;
            tx_bc_r <= tx_bc_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_pb_r <= tx_pb_nxt;
            tx_sb_r <= tx_sb_nxt;
            txd_r <= txd_line & ~cfg_r.brk;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rbr_r <= 8'h00;
            rbr_full_r <= 1'b0;
            thr_r <= 8'h00;
            thr_v_r <= 1'b0;
            ptx_busy_r <= 1'b0;
            ptx_hdr_r <= 1'b0;
            ptx_type_r <= 8'h00;
            ptx_len_r <= 7'h00;
            ptx_ptr_r <= 7'h00;
            pk_st_r <= P_IDLE;
            pk_cnt_r <= 7'h00;
            pk_tot_r <= 7'h00;
            pk_type_r <= 8'h00;
        end else begin
            if (rx_direct) begin
                rbr_r <= rx_data;
            end
            rbr_full_r <= rx_direct | (rbr_full_r & ~rbr_rd);
            if (wr & hit_data & ~cfg_r.hci & ~thr_v_r) begin
                thr_r <= pwdata[7:0];
            end
            // A write refused while full must not re-arm the byte that is being taken
            thr_v_r <= (wr & hit_data & ~cfg_r.hci & ~thr_v_r) | (thr_v_r & ~(tx_take & ~cfg_r.hci));
            if (ptx_start) begin
                ptx_busy_r <= 1'b1;
                ptx_hdr_r <= ~pwdata[hup_pkg::PC_CONT];
                ptx_type_r <= pwdata[hup_pkg::PC_TYPE_LSB +: 8];
                ptx_len_r <= (pct_len > hup_pkg::BUF_DEPTH_L) ? hup_pkg::BUF_DEPTH_L : pct_len;
                ptx_ptr_r <= 7'h00;
            end else if (tx_take & cfg_r.hci) begin
                if (ptx_hdr_r) begin
                    ptx_hdr_r <= 1'b0;
                end else begin
                    ptx_ptr_r <= ptx_ptr_r + 7'h01;
                end
            end else if (ptx_busy_r & ~ptx_more & (tx_fin | ~cfg_r.hci)) begin
                ptx_busy_r <= 1'b0;
            end
            pk_st_r <= cfg_r.hci ? pk_st_nxt : P_IDLE;
            pk_cnt_r <= pk_cnt_nxt;
            pk_tot_r <= pk_tot_nxt;
            pk_type_r <= pk_type_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r;
    assign uart_txd = txd_r;
    assign irq = |(st_r & en_r);
    assign err_irq = |(st_r & hup_pkg::ERR_MASK);
endmodule

// [test/hci_uart_packet_port_test.sv]
/* Self-checking bench for hup_top: APB tasks reach the registers, a host model drives the line.
   Assumes the checker is bound in its own file and a 10 MHz clock. */
`timescale 1ns/1ps
module hci_uart_packet_port_test;
    logic clk, sys_rst, psel, penable, pwrite, uart_rxd, uart_txd, pready, pslverr, irq, err_irq, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] got, d;
    logic [7:0] pk [4] = '{8'h04, 8'h0e, 8'h01, 8'h55};
    logic [4:0] tk [3] = '{hup_pkg::TICKS_X16, hup_pkg::TICKS_X24, hup_pkg::TICKS_X13};
    int bad_count = 0, check_count = 0, cyc = 0, per;
    hup_top hup_top_i (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .uart_rxd, .uart_txd, .irq, .err_irq);
    hup_host_model hup_host_model_i (.clk, .txd(uart_txd), .rxd(uart_rxd));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic snd(input logic [7:0] v, input logic p, input int n);
        hup_host_model_i.send({1'b1, p, v, 1'b0}, n, per);
    endtask
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        apb(0, hup_pkg::OFS_CTRL, 0);
        chk(rdat, 32'h0000_0010);
        apb(0, 12'h020, 0);
        chk(32'(perr), 32'h0000_0001);
        apb(1, hup_pkg::OFS_DIV, 1);
        apb(1, hup_pkg::OFS_ENABLE, 32'h0000_01ff);
        $display("reset test done");
        for (int i = 0; i < 3; i++) begin
            per = 2 * int'(tk[i]); // Divisor 1 doubles each base tick
            d = 8'ha5 ^ 8'(i);
            apb(1, hup_pkg::OFS_CTRL, 32'h0000_0050 | 32'(i << 2));
            snd(d, ^d, 11);
            apb(0, hup_pkg::OFS_STATUS, 0);
            chk(rdat & 32'h0000_003d, 32'h0000_0001);
            @(negedge clk);
            chk(32'(irq), 32'h0000_0001);
            apb(0, hup_pkg::OFS_DATA, 0);
            chk(rdat, {24'h0, d});
            fork
                hup_host_model_i.recv(per, got);
                apb(1, hup_pkg::OFS_DATA, {24'h0, ~d});
            join
            chk({24'h0, got}, {24'h0, ~d});
            repeat (3 * per) @(posedge clk);
            apb(1, hup_pkg::OFS_CLEAR, 32'h0000_01ff);
            @(negedge clk);
            chk(32'(irq), 32'h0000_0000);
        end
        $display("direct path test done");
        per = 32;
        apb(1, hup_pkg::OFS_CTRL, 32'h0000_0050);
        apb(1, hup_pkg::OFS_ENABLE, 0);
        snd(8'h3c, 1'b1, 11);
        apb(0, hup_pkg::OFS_STATUS, 0);
        chk(rdat & 32'h0000_003c, 32'h0000_0004);
        @(negedge clk);
        chk(32'({irq, err_irq}), 32'h0000_0001);
        apb(1, hup_pkg::OFS_ENABLE, 32'h0000_0004);
        @(negedge clk);
        chk(32'(irq), 32'h0000_0001);
        apb(1, hup_pkg::OFS_CLEAR, 32'h0000_01ff);
        hup_host_model_i.send(12'h000, 11, per); // Stop bit low too, so the character is a break
        apb(0, hup_pkg::OFS_STATUS, 0);
        chk(rdat & 32'h0000_003c, 32'h0000_0020);
        apb(1, hup_pkg::OFS_CTRL, 32'h0000_0052);
        repeat (2) @(negedge clk);
        chk(32'(uart_txd), 32'h0000_0000);
        $display("error and break test done");
        apb(1, hup_pkg::OFS_CTRL, 32'h0000_0011);
        apb(1, hup_pkg::OFS_CLEAR, 32'h0000_01ff);
        apb(1, hup_pkg::OFS_ENABLE, 32'h0000_0040);
        foreach (pk[j]) snd(pk[j], 1'b1, 10);
        apb(0, hup_pkg::OFS_PKTSTAT, 0);
        chk(rdat, 32'h0001_0404);
        @(negedge clk);
        chk(32'(irq), 32'h0000_0001);
        apb(0, 12'h10c, 0);
        chk(rdat, 32'h0000_0055);
        fork
            hup_host_model_i.recv(per, got);
            apb(1, hup_pkg::OFS_PKTCTRL, 32'h0001_0001);
        join
        chk({24'h0, got}, 32'h0000_0001);
        $display("packet test done");
        end_sim();
    end
endmodule

// [test/hup_host_model.sv]
/* Behavioural external host on the serial line: sends framed characters and receives them.
   Assumes the bench passes the bit period in clocks that matches the device setting. */
`timescale 1ns/1ps
module hup_host_model (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    // Line idles high between frames, as a real host would leave it
    task automatic send(input logic [11:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (per) @(posedge clk);
        end
        // A high last bit already idles the line; a second write here would race the next frame
        if (f[n-1] !== 1'b1) rxd <= 1'b1;
    endtask
    // Samples at bit centres, LSB first; parity and stop are left to the line
    task automatic recv(input int per, output logic [7:0] v);
        while (txd !== 1'b0) @(posedge clk);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (per) @(posedge clk);
            v[i] = txd;
        end
    endtask
endmodule

// [test/hup_top_asserts.sv]
/* Port checker for hup_top: APB answer, break, reset levels and interrupt clearing.
   Assumes one clock domain with synchronous active-high reset. */
`timescale 1ns/1ps
module hup_top_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic uart_txd,
    input wire logic irq,
    input wire logic err_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic wr = psel && penable && pwrite;
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_unmap; psel && !penable && paddr == 12'h020 |=> pslverr && prdata == 32'h0000_0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_map; psel && !penable && paddr == hup_pkg::OFS_DIV |=> !pslverr; endproperty
    a_map: assert property (p_map) else $error("divisor access refused");
    property p_hold; psel && penable |=> $stable(prdata) && $stable(pslverr); endproperty
    a_hold: assert property (p_hold) else $error("read data moved after access");
    property p_brk; wr && paddr == hup_pkg::OFS_CTRL && pwdata[1] |-> ##[1:2] !uart_txd; endproperty
    a_brk: assert property (p_brk) else $error("break not driven");
    property p_rst; $fell(sys_rst) |-> uart_txd && !irq && !err_irq; endproperty
    a_rst: assert property (p_rst) else $error("bad levels after reset");
    property p_errclr; $fell(err_irq) |-> $past(wr && paddr == hup_pkg::OFS_CLEAR); endproperty
    a_errclr: assert property (p_errclr) else $error("error interrupt dropped alone");
    property p_irqclr; $fell(irq) |-> $past(wr && (paddr == hup_pkg::OFS_CLEAR || paddr == hup_pkg::OFS_ENABLE)); endproperty
    a_irqclr: assert property (p_irqclr) else $error("interrupt dropped alone");
endmodule
bind hup_top hup_top_asserts hup_top_asserts_i (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .uart_txd, .irq, .err_irq);
